// >>> adc_readout_pkg.sv
// constants, types and state layout shared by the serial converter readout
// ----------------------------------------------------------------------------
// Contract
// - a low select_shutdown_n means selected and running, a high one means shutdown.
// - every result word carried on serial_result_out has twelve data bits.
// - the serial output driver turns on at the second data_shift_clock falling edge after select falls.
// - once the driver is on, one null bit comes first and then the twelve result bits on the next twelve edges.
// - every new output bit is launched on a falling edge of data_shift_clock.
// - data_shift_clock alone paces both the shifting and the conversion, one step per clock period.
// - at the start of a conversion the input is captured and then isolated for the rest of the conversion.
// - the result leaves with its most significant bit first.
// - the bits shifted out belong to the conversion in progress, never to an earlier one.
// - if clocking goes on after the first pass, the same result is sent again least significant bit first.
// - the null bit ahead of the result is low and lasts one full clock period.
// - after result_msb is repeated the output goes to high impedance and further clocks are ignored.
// - a new conversion starts only after select_shutdown_n has gone high and low again.
// - the result is plain unsigned binary, all ones at full scale less one step, top bit alone at mid scale.
// ----------------------------------------------------------------------------
package adc_readout_pkg;

  // ----------------------------------------------------------------------------
  // widths and bit positions
  // ----------------------------------------------------------------------------
  localparam int RES_BITS = 12;
  localparam int CNT_BITS = 4;
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_BITS-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_BITS-1:0] MSB_IDX = 4'hB;
  localparam logic [CNT_BITS-1:0] FIRST_REPEAT_IDX = 4'h1;
  localparam logic [CNT_BITS-1:0] REPEAT_END_IDX = 4'hC;
  localparam logic [CNT_BITS-1:0] SAMPLE_EDGES = 4'h1;

  // ----------------------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------------------
  localparam logic [RES_BITS-1:0] RESULT_RESET = 12'h000;
  localparam logic [RES_BITS-1:0] MID_SCALE_TRIAL = 12'h800;
  localparam logic NULL_BIT = 1'b0;

  // ----------------------------------------------------------------------------
  // sequencer phases and state record
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SAMPLE,
    PH_MSB,
    PH_LSB,
    PH_DONE
  } phase_t;

  typedef struct packed {
    logic sel_meta;
    logic sel_sync;
    logic clk_meta;
    logic clk_sync;
    logic clk_prev;
    logic cmp_meta;
    logic cmp_sync;
    phase_t phase;
    logic [CNT_BITS-1:0] cnt;
    logic [RES_BITS-1:0] result;
    logic [RES_BITS-1:0] trial;
    logic dout;
    logic oe;
    logic armed;
    logic track;
    logic push;
  } conv_state_t;

  // select stages reset low: a select held low across reset must not count as seen high
  localparam conv_state_t CONV_RESET = '{
    sel_meta: 1'b0, sel_sync: 1'b0, clk_meta: 1'b0, clk_sync: 1'b0, clk_prev: 1'b0,
    cmp_meta: 1'b0, cmp_sync: 1'b0, phase: PH_IDLE, cnt: 4'h0, result: 12'h000,
    trial: 12'h000, dout: 1'b0, oe: 1'b0, armed: 1'b0, track: 1'b0, push: 1'b0};

  // finished word handed to the parallel side
  typedef struct packed {
    logic [RES_BITS-1:0] code;
  } result_word_t;

endpackage

// >>> result_buffer.sv
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module result_buffer #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ----------------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("result_buffer depth must be a power of two, two or more");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("result_buffer width must be positive");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } buf_state_t;

  buf_state_t st_ff;
  buf_state_t nxt_st;
  logic full;
  logic empty;

  // pointers carry one extra wrap bit so full and empty stay distinct
  assign empty = (st_ff.wr == st_ff.rd);
  assign full = (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]) && (st_ff.wr[AW] != st_ff.rd[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_ff.mem[st_ff.rd[AW-1:0]];

  // write on accepted push, advance read on accepted pop
  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) begin
      nxt_st.mem[st_ff.wr[AW-1:0]] = in_data;
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else if (clock_en) begin
      st_ff <= nxt_st;
    end
  end

endmodule

// >>> serial_sar_adc_readout.sv
// conversion sequencer and serial result shifter of a 12-bit sar converter
`timescale 1ns/1ps
module serial_sar_adc_readout #(
  parameter int BUF_DEPTH = 2
) (
  // system clock, reset and freeze
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // host pins, asynchronous to clock
  input wire logic select_shutdown_n,
  input wire logic data_shift_clock,
  output logic serial_result_out,
  output logic serial_result_oe,
  // analog front end
  input wire logic compare_above,
  output logic input_track,
  output logic [adc_readout_pkg::RES_BITS-1:0] dac_trial,
  // parallel result stream
  output logic result_valid,
  input wire logic result_ready,
  output logic [adc_readout_pkg::RES_BITS-1:0] result_data,
  output logic converting
);

  // ----------------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------------
  if (BUF_DEPTH < 2) begin : g_bad_depth
    $error("serial_sar_adc_readout needs a buffer of two entries or more");
  end

  adc_readout_pkg::conv_state_t st_ff;
  adc_readout_pkg::conv_state_t nxt_st;
  logic shift_fall;
  logic buf_in_ready;
  adc_readout_pkg::result_word_t push_word;

  // falling edge of the host clock, seen only through the second sync stage
  assign shift_fall = st_ff.clk_prev && !st_ff.clk_sync;

  // ----------------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // two-stage synchronisers on every pin-side input
    nxt_st.sel_meta = select_shutdown_n;
    nxt_st.sel_sync = st_ff.sel_meta;
    nxt_st.clk_meta = data_shift_clock;
    nxt_st.clk_sync = st_ff.clk_meta;
    nxt_st.clk_prev = st_ff.clk_sync;
    nxt_st.cmp_meta = compare_above;
    nxt_st.cmp_sync = st_ff.cmp_meta;
    nxt_st.push = 1'b0;
    if (st_ff.sel_sync) begin
      // shutdown: driver off, sequencer idle, ready for the next falling select
      nxt_st.phase = adc_readout_pkg::PH_IDLE;
      nxt_st.oe = 1'b0;
      nxt_st.dout = adc_readout_pkg::NULL_BIT;
      nxt_st.track = 1'b0;
      nxt_st.armed = 1'b1;
    end else begin
      unique case (st_ff.phase)
        adc_readout_pkg::PH_IDLE: begin
          // a full buffer holds off the start, so no finished word is ever dropped
          if (st_ff.armed && buf_in_ready) begin
            nxt_st.phase = adc_readout_pkg::PH_SAMPLE;
            nxt_st.armed = 1'b0;
            nxt_st.track = 1'b1;
            nxt_st.cnt = adc_readout_pkg::CNT_ZERO;
          end
        end
        adc_readout_pkg::PH_SAMPLE: begin
          if (shift_fall) begin
            if (st_ff.cnt == adc_readout_pkg::SAMPLE_EDGES) begin
              // second falling edge: hold the input, drive the null bit
              nxt_st.phase = adc_readout_pkg::PH_MSB;
              nxt_st.oe = 1'b1;
              nxt_st.dout = adc_readout_pkg::NULL_BIT;
              nxt_st.track = 1'b0;
              nxt_st.cnt = adc_readout_pkg::MSB_IDX;
              nxt_st.result = adc_readout_pkg::RESULT_RESET;
              nxt_st.trial = adc_readout_pkg::MID_SCALE_TRIAL;
            end else begin
              nxt_st.cnt = 4'(st_ff.cnt + adc_readout_pkg::CNT_ONE);
            end
          end
        end
        adc_readout_pkg::PH_MSB: begin
          // one decision per clock period, shown as soon as it is made
          if (shift_fall) begin
            nxt_st.dout = st_ff.cmp_sync;
            nxt_st.result[st_ff.cnt] = st_ff.cmp_sync;
            nxt_st.trial[st_ff.cnt] = st_ff.cmp_sync;
            if (st_ff.cnt == adc_readout_pkg::CNT_ZERO) begin
              // twelve bits decided: hand the word over and start the repeat
              nxt_st.phase = adc_readout_pkg::PH_LSB;
              nxt_st.cnt = adc_readout_pkg::FIRST_REPEAT_IDX;
              nxt_st.push = 1'b1;
            end else begin
              nxt_st.trial[4'(st_ff.cnt - adc_readout_pkg::CNT_ONE)] = 1'b1;
              nxt_st.cnt = 4'(st_ff.cnt - adc_readout_pkg::CNT_ONE);
            end
          end
        end
        adc_readout_pkg::PH_LSB: begin
          // repeat pass walks from bit one back up to the top bit
          if (shift_fall) begin
            if (st_ff.cnt == adc_readout_pkg::REPEAT_END_IDX) begin
              nxt_st.phase = adc_readout_pkg::PH_DONE;
              nxt_st.oe = 1'b0;
              nxt_st.dout = adc_readout_pkg::NULL_BIT;
            end else begin
              nxt_st.dout = st_ff.result[st_ff.cnt];
              nxt_st.cnt = 4'(st_ff.cnt + adc_readout_pkg::CNT_ONE);
            end
          end
        end
        adc_readout_pkg::PH_DONE: begin
          // further clocks have no effect until select goes high
          nxt_st.oe = 1'b0;
        end
      endcase
    end
  end

  // state register, frozen while clock_en is low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= adc_readout_pkg::CONV_RESET;
    end else if (clock_en) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------------
  // result buffer and outputs
  // ----------------------------------------------------------------------------
  // the word pushed is the one just finished, never an older one
  assign push_word.code = st_ff.result;

  result_buffer #(
    .WIDTH(adc_readout_pkg::RES_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_result_buffer (
    .clock(clock),
    .reset_n(reset_n),
    .clock_en(clock_en),
    .in_valid(st_ff.push),
    .in_ready(buf_in_ready),
    .in_data(push_word.code),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

  // all pin-side outputs straight from the state register
  assign serial_result_out = st_ff.dout;
  assign serial_result_oe = st_ff.oe;
  assign input_track = st_ff.track;
  assign dac_trial = st_ff.trial;
  assign converting = (st_ff.phase != adc_readout_pkg::PH_IDLE);

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence start_seq;
    clock_en && !st_ff.sel_sync && st_ff.phase == adc_readout_pkg::PH_SAMPLE && shift_fall
      && st_ff.cnt == adc_readout_pkg::SAMPLE_EDGES;
  endsequence

  sequence null_seq;
    clock_en && st_ff.oe && !st_ff.dout && !st_ff.track;
  endsequence

  // first result edge and last repeat edge of a frame
  sequence first_bit_seq;
    clock_en && !st_ff.sel_sync && st_ff.phase == adc_readout_pkg::PH_MSB && shift_fall
      && st_ff.cnt == adc_readout_pkg::MSB_IDX;
  endsequence

  sequence repeat_end_seq;
    clock_en && !st_ff.sel_sync && st_ff.phase == adc_readout_pkg::PH_LSB && shift_fall
      && st_ff.cnt == adc_readout_pkg::REPEAT_END_IDX;
  endsequence

  shutdown_hiz_a: assert property (
    clock_en && st_ff.sel_sync |=> !st_ff.oe && st_ff.phase == adc_readout_pkg::PH_IDLE)
    else $error("output driven or sequencer busy during shutdown");

  enable_second_edge_a: assert property (
    $rose(st_ff.oe) |-> $past(st_ff.phase) == adc_readout_pkg::PH_SAMPLE
      && $past(st_ff.cnt) == adc_readout_pkg::SAMPLE_EDGES)
    else $error("output enabled on the wrong edge");

  null_bit_low_a: assert property (
    start_seq |=> null_seq)
    else $error("null bit not low with input held");

  null_then_msb_a: assert property (
    start_seq |=> st_ff.phase == adc_readout_pkg::PH_MSB && st_ff.cnt == adc_readout_pkg::MSB_IDX)
    else $error("first result bit not lined up after null bit");

  bit_is_decision_a: assert property (
    clock_en && !st_ff.sel_sync && st_ff.phase == adc_readout_pkg::PH_MSB && shift_fall
      |=> st_ff.dout == $past(st_ff.cmp_sync) && st_ff.result[$past(st_ff.cnt)] == st_ff.dout)
    else $error("shifted bit differs from the fresh decision");

  word_complete_a: assert property (
    $rose(st_ff.push) |-> $past(st_ff.phase) == adc_readout_pkg::PH_MSB
      && $past(st_ff.cnt) == adc_readout_pkg::CNT_ZERO && buf_in_ready)
    else $error("word handed over before twelve bits were decided");

  repeat_lsb_a: assert property (
    clock_en && !st_ff.sel_sync && st_ff.phase == adc_readout_pkg::PH_LSB && shift_fall
      && st_ff.cnt != adc_readout_pkg::REPEAT_END_IDX |=> st_ff.dout == st_ff.result[$past(st_ff.cnt)])
    else $error("repeated bit does not match the stored result");

  done_hiz_a: assert property (
    st_ff.phase == adc_readout_pkg::PH_DONE |-> !st_ff.oe)
    else $error("output still driven after the repeat pass");

  falling_launch_a: assert property (
    $changed(st_ff.dout) && st_ff.oe && $past(st_ff.oe) |-> $past(shift_fall))
    else $error("output bit changed away from a falling edge");

  input_isolated_a: assert property (
    st_ff.oe |-> !st_ff.track)
    else $error("input connected while converting");

  restart_needs_high_a: assert property (
    clock_en && !st_ff.sel_sync && st_ff.phase == adc_readout_pkg::PH_IDLE && !st_ff.armed
      |=> st_ff.phase == adc_readout_pkg::PH_IDLE)
    else $error("conversion restarted without select going high");

  // ----------------------------------------------------------------------------
  // phase invariants: idle, sample and the standing null bit pin down what the pins may show
  // ----------------------------------------------------------------------------

  idle_quiet_a: assert property (
    st_ff.phase == adc_readout_pkg::PH_IDLE |-> !st_ff.oe && !st_ff.track)
    else $error("driver or input switch on while idle");

  sample_track_a: assert property (
    st_ff.phase == adc_readout_pkg::PH_SAMPLE |-> st_ff.track && !st_ff.oe)
    else $error("input not connected during the sample window");

  sample_window_a: assert property (
    st_ff.phase == adc_readout_pkg::PH_SAMPLE |-> st_ff.cnt <= adc_readout_pkg::SAMPLE_EDGES)
    else $error("sample window counted past the second falling edge");

  null_stands_a: assert property (
    st_ff.phase == adc_readout_pkg::PH_MSB && st_ff.cnt == adc_readout_pkg::MSB_IDX
      |-> st_ff.oe && st_ff.dout == adc_readout_pkg::NULL_BIT)
    else $error("null bit did not stand until the first result edge");

  step_on_fall_a: assert property (
    clock_en && !st_ff.sel_sync && !shift_fall && st_ff.phase != adc_readout_pkg::PH_IDLE
      |=> $stable(st_ff.phase) && $stable(st_ff.cnt) && $stable(st_ff.dout))
    else $error("sequencer stepped without a falling host clock edge");

  // ----------------------------------------------------------------------------
  // frame edges and word hand-over
  // ----------------------------------------------------------------------------

  trial_mid_scale_a: assert property (
    start_seq |=> st_ff.trial == adc_readout_pkg::MID_SCALE_TRIAL)
    else $error("first trial is not mid scale");

  fresh_result_a: assert property (
    start_seq |=> st_ff.result == adc_readout_pkg::RESULT_RESET)
    else $error("an older result was carried into a new conversion");

  msb_first_a: assert property (
    first_bit_seq |=> st_ff.dout == st_ff.trial[adc_readout_pkg::MSB_IDX]
      && st_ff.cnt == adc_readout_pkg::MSB_IDX - adc_readout_pkg::CNT_ONE)
    else $error("first result bit is not the top bit");

  word_matches_a: assert property (
    st_ff.push |-> st_ff.result == st_ff.trial)
    else $error("handed-over word differs from the finished trial");

  push_single_a: assert property (
    clock_en && st_ff.push |=> !st_ff.push)
    else $error("one conversion handed over more than one word");

  lsb_pass_start_a: assert property (
    st_ff.push |-> st_ff.phase == adc_readout_pkg::PH_LSB
      && st_ff.cnt == adc_readout_pkg::FIRST_REPEAT_IDX)
    else $error("repeat pass does not start at the bit above the last one sent");

  repeat_end_a: assert property (
    repeat_end_seq |=> st_ff.phase == adc_readout_pkg::PH_DONE && !st_ff.oe)
    else $error("output still driven after the repeated top bit");

  done_ignores_a: assert property (
    clock_en && !st_ff.sel_sync && st_ff.phase == adc_readout_pkg::PH_DONE
      |=> st_ff.phase == adc_readout_pkg::PH_DONE && $stable(st_ff.result))
    else $error("clocks after the repeat pass changed the converter");

endmodule

// >>> adc_host_model.sv
// host side model: select and data clock driver, rising-edge sampler, comparator
`timescale 1ns/1ps
module adc_host_model #(
  parameter int HALF = 12
) (
  // pacing clock
  input wire logic clock,
  // host pins
  output logic select_shutdown_n,
  output logic data_shift_clock,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  // analog side
  input wire logic input_track,
  input wire logic [adc_readout_pkg::RES_BITS-1:0] dac_trial,
  output logic compare_above
);
  // ----------------------------------------------------------------------------
  // pins and capture record
  // ----------------------------------------------------------------------------
  logic [adc_readout_pkg::RES_BITS-1:0] level;
  logic [31:0] seen_oe;
  logic [31:0] seen_out;
  logic [31:0] seen_trk;

  // select idles high and the data clock stands still low outside frames
  initial begin
    select_shutdown_n = 1'b1;
    data_shift_clock = 1'b0;
    level = 12'h000;
  end

  // ideal comparator on the held level
  always @(posedge clock) begin
    compare_above <= (level >= dac_trial);
  end

  // one frame; sample k is taken at rise k, the last one with the clock left low
  task automatic frame(input logic [11:0] lvl, input int falls, input bit rel);
    int r;
    @(posedge clock);
    level <= lvl;
    select_shutdown_n <= 1'b0;
    seen_oe = '0;
    seen_out = '0;
    seen_trk = '0;
    repeat (HALF) @(posedge clock);
    for (r = 1; r <= falls + 1; r++) begin
      seen_oe[r] = serial_result_oe;
      seen_out[r] = serial_result_out;
      seen_trk[r] = input_track;
      if (r <= falls) begin
        data_shift_clock <= 1'b1;
        repeat (HALF) @(posedge clock);
        data_shift_clock <= 1'b0;
        repeat (HALF) @(posedge clock);
      end
    end
    if (rel) begin
      release_sel();
    end
  endtask

  // select high long enough to be seen and to re-arm
  task automatic release_sel();
    @(posedge clock);
    select_shutdown_n <= 1'b1;
    repeat (2 * HALF) @(posedge clock);
  endtask
endmodule

// >>> serial_sar_adc_readout_tb.sv
// self-checking bench of the serial converter readout
`timescale 1ns/1ps
module serial_sar_adc_readout_tb;
  // ----------------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------------
  logic clock = 1'b0;
  logic reset_n;
  logic clock_en;
  logic result_ready;
  logic select_shutdown_n;
  logic data_shift_clock;
  logic serial_result_out;
  logic serial_result_oe;
  logic compare_above;
  logic input_track;
  logic [11:0] dac_trial;
  logic result_valid;
  logic [11:0] result_data;
  logic converting;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] lfsr = 32'hE3A1;
  logic [11:0] a;
  logic [11:0] b;
  logic [11:0] corners [4] = '{12'h800, 12'hFFF, 12'h7FF, 12'h000};

  always #20 clock = ~clock;

  serial_sar_adc_readout dut_u (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
    .select_shutdown_n(select_shutdown_n), .data_shift_clock(data_shift_clock),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .compare_above(compare_above), .input_track(input_track), .dac_trial(dac_trial),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .converting(converting));

  adc_host_model host_u (.clock(clock), .select_shutdown_n(select_shutdown_n),
    .data_shift_clock(data_shift_clock), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .input_track(input_track),
    .dac_trial(dac_trial), .compare_above(compare_above));

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // sample k: null at 3, msb first from 4, lsb-first repeat from 16
  function automatic logic exp_bit(input logic [11:0] lvl, input int r);
    if (r == 3) begin
      return 1'b0;
    end
    if (r <= 15) begin
      return lvl[15 - r];
    end
    return lvl[r - 15];
  endfunction

  function automatic logic exp_oe(input bit on, input int r);
    return on && r >= 3 && r <= 26;
  endfunction

  // one frame and the comparisons of every captured sample
  task automatic run(input logic [11:0] lvl, input int falls, input bit rel, input bit on);
    int r;
    host_u.frame(lvl, falls, rel);
    for (r = 1; r <= falls + 1; r++) begin
      check(host_u.seen_oe[r], exp_oe(on, r));
      if (exp_oe(on, r)) begin
        check(host_u.seen_out[r], exp_bit(lvl, r));
      end
      if (on && r >= 2 && r <= 15) begin
        check(host_u.seen_trk[r], r == 2);
      end
    end
  endtask

  // bounded wait for a word, compare, then pop it
  task automatic drain(input logic [11:0] exp);
    int n;
    n = 0;
    while (result_valid !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n >= 200) begin
      fails++;
      conclude();
    end else begin
      check(result_data, exp);
      @(posedge clock);
      result_ready <= 1'b1;
      @(posedge clock);
      result_ready <= 1'b0;
      @(negedge clock);
    end
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    clock_en = 1'b1;
    result_ready = 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (8) @(posedge clock);
    @(negedge clock);
    check(serial_result_oe, 1'b0);
    check(converting, 1'b0);
    // code boundaries, clocked past the tri-state point
    foreach (corners[i]) begin
      run(corners[i], 30, 1'b1, 1'b1);
      drain(corners[i]);
    end
    $display("test corners done");
    // random levels back to back
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      run(lfsr[11:0], 26, 1'b1, 1'b1);
      drain(lfsr[11:0]);
    end
    $display("test random done");
    // select kept low: a second burst must not restart
    run(12'h5A5, 30, 1'b0, 1'b1);
    run(12'h3C3, 26, 1'b1, 1'b0);
    drain(12'h5A5);
    check(result_valid, 1'b0);
    $display("test retrigger done");
    // two words fill the buffer, a third start is held off
    lfsr = lfsr_next(lfsr);
    a = lfsr[11:0];
    lfsr = lfsr_next(lfsr);
    b = lfsr[11:0];
    run(a, 26, 1'b1, 1'b1);
    run(b, 26, 1'b1, 1'b1);
    run(12'h123, 26, 1'b1, 1'b0);
    drain(a);
    drain(b);
    check(result_valid, 1'b0);
    $display("test buffer done");
    // abort in mid result: driver off, no word delivered
    run(12'hABC, 8, 1'b0, 1'b1);
    host_u.release_sel();
    @(negedge clock);
    check(serial_result_oe, 1'b0);
    check(converting, 1'b0);
    check(result_valid, 1'b0);
    $display("test abort done");
    // reset while selected: the held-low select must not start a conversion
    run(12'h456, 8, 1'b0, 1'b1);
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (8) @(posedge clock);
    @(negedge clock);
    check(converting, 1'b0);
    run(12'h456, 26, 1'b1, 1'b0);
    check(result_valid, 1'b0);
    $display("test reset done");
    conclude();
  end
endmodule
